/* common/lsb_pkg.sv */
/*
 * Package for the logic stack and bitwise unit: command codes, widths,
 * reset values and the packed carriers shared by the unit and its stack.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package lsb_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int STACK_DEPTH = 9;
   localparam int STATE_BITS = 8;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_LEVEL = 1'h0;
   localparam logic [DATA_W-1:0] RST_RESULT = 32'h0000_0000;
   localparam logic [STATE_BITS-1:0] RST_STATE = 8'h00;

   // Stack commands
   typedef enum logic [2:0] {
      LSB_STK_NONE = 3'h0,
      LSB_STK_AND = 3'h1,
      LSB_STK_OR = 3'h2,
      LSB_STK_DUP = 3'h3,
      LSB_STK_COPY = 3'h4,
      LSB_STK_POP = 3'h5,
      // Constant loads, so the stack can hold something to combine
      LSB_STK_PUSH0 = 3'h6,
      LSB_STK_PUSH1 = 3'h7
   } lsb_stk_cmd_t;

   // Bitwise operations
   typedef enum logic [1:0] {
      LSB_OP_AND = 2'h0,
      LSB_OP_OR = 2'h1,
      LSB_OP_XOR = 2'h2,
      LSB_OP_INV = 2'h3
   } lsb_op_t;

   // Operand widths
   typedef enum logic [1:0] {
      LSB_W_BYTE = 2'h0,
      LSB_W_WORD = 2'h1,
      LSB_W_DWORD = 2'h2
   } lsb_width_t;

   // Bitwise request carrier
   typedef struct packed {
      logic valid;
      lsb_op_t op;
      lsb_width_t width;
      logic [DATA_W-1:0] first_operand;
      logic [DATA_W-1:0] second_operand;
   } lsb_alu_req_t;

   // Bitwise result carrier
   typedef struct packed {
      logic valid;
      lsb_width_t width;
      logic [DATA_W-1:0] data;
      logic zero_update;
      logic zero_value;
   } lsb_alu_res_t;

   // Sequence step request: one evaluation of transitions
   typedef struct packed {
      logic valid;
      logic [STATE_BITS-1:0] current;
      logic [STATE_BITS-1:0] targets;
      logic [STATE_BITS-1:0] cond;
      logic [STATE_BITS-1:0] join_need;
      logic [STATE_BITS-1:0] join_target;
      logic exclusive;
   } lsb_seq_req_t;

endpackage

/* verilog/lsb_stack.sv */
/*
 * Bit stack of the logic unit: combine, duplicate, copy and pop.
 * Assumes one stack command per clock from the sequencer.
 */
`timescale 1ns/1ps

module lsb_stack #(
   parameter int DEPTH = lsb_pkg::STACK_DEPTH
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire lsb_pkg::lsb_stk_cmd_t cmd_in,
   output logic [DEPTH-1:0] levels_out
);

   // ----------------------------------------------------------------
   // Next-value decode
   // ----------------------------------------------------------------
   logic [DEPTH-1:0] stk;
   logic [DEPTH-1:0] next_stk;
   logic [DEPTH-1:0] shift_up;
   logic [DEPTH-1:0] shift_down;

   // Pop and combine drop level 0; bottom refilled with zero
   // [RULE16] zero-fill vacated bottom
   assign shift_up = {1'b0, stk[DEPTH-1:1]};
   // [RULE3] duplicate drops bottom
   assign shift_down = {stk[DEPTH-2:0], stk[0]};

   always_comb begin
      case (cmd_in)
         // [RULE1] and combine
         lsb_pkg::LSB_STK_AND: next_stk = {shift_up[DEPTH-1:1], stk[0] & stk[1]};
         // [RULE2] or combine
         lsb_pkg::LSB_STK_OR: next_stk = {shift_up[DEPTH-1:1], stk[0] | stk[1]};
         lsb_pkg::LSB_STK_DUP: next_stk = shift_down;
         // [RULE4] copy second to top
         lsb_pkg::LSB_STK_COPY: next_stk = {stk[DEPTH-1:1], stk[1]};
         // [RULE5] pop top
         lsb_pkg::LSB_STK_POP: next_stk = shift_up;
         // Constant loads push down like duplicate, bottom level lost
         lsb_pkg::LSB_STK_PUSH0: next_stk = {stk[DEPTH-2:0], 1'b0};
         lsb_pkg::LSB_STK_PUSH1: next_stk = {stk[DEPTH-2:0], 1'b1};
         default: next_stk = stk;
      endcase
   end

   // Stack storage
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         stk <= {DEPTH{lsb_pkg::RST_LEVEL}};
      end else begin
         stk <= next_stk;
      end
   end

   assign levels_out = stk;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_and_combine: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE1]
      cmd_in == lsb_pkg::LSB_STK_AND |=> stk[0] == ($past(stk[0]) & $past(stk[1])))
      else $error("and combine result wrong");
   a_or_combine: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE2]
      cmd_in == lsb_pkg::LSB_STK_OR |=> stk[0] == ($past(stk[0]) | $past(stk[1])))
      else $error("or combine result wrong");
   a_dup_push: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE3]
      cmd_in == lsb_pkg::LSB_STK_DUP |=> stk[1] == $past(stk[0]) && stk[0] == $past(stk[0]))
      else $error("duplicate push wrong");
   a_copy_second: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE4]
      cmd_in == lsb_pkg::LSB_STK_COPY |=> stk[0] == $past(stk[1]) && stk[1] == $past(stk[1]))
      else $error("copy second wrong");
   a_pop_top: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE5]
      cmd_in == lsb_pkg::LSB_STK_POP |=> stk[0] == $past(stk[1]))
      else $error("pop wrong");
   a_bottom_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE16]
      cmd_in inside {lsb_pkg::LSB_STK_AND, lsb_pkg::LSB_STK_OR, lsb_pkg::LSB_STK_POP}
      |=> stk[DEPTH-1] == 1'b0)
      else $error("bottom not zeroed");

endmodule // lsb_stack

/* verilog/lsb_unit.sv */
/*
 * Logic stack and bitwise unit: bit stack, byte/word/double-word logic
 * with inversion and zero flag, and sequence state-bit stepping.
 * Assumes the sequencer gives one request of each kind per clock and
 * that operands are synchronous to core_clk_in.
 */
`timescale 1ns/1ps

// Functional notes
// [RULE1] And-combine ANDs the top two levels into the top and drops one level.
// [RULE2] Or-combine ORs the top two levels into the top and drops one level.
// [RULE3] Duplicate-push copies the top down one level, losing the bottom.
// [RULE4] Copy-second writes level two into the top, all else unchanged.
// [RULE5] Pop removes the top so every lower level moves up one.
// [RULE6] Byte logic forms AND, OR or XOR of two 8-bit operands into 8 bits.
// [RULE7] Word logic forms AND, OR or XOR of two 16-bit operands into 16 bits.
// [RULE8] Double-word logic forms AND, OR or XOR of two 32-bit operands.
// [RULE9] Byte invert writes the ones complement and updates the zero flag.
// [RULE10] Word invert writes the ones complement and updates the zero flag.
// [RULE11] Double-word invert writes the ones complement of 32 bits.
// [RULE12] One true condition activates all its target states in one step.
// [RULE13] A join target is set only when all needed completion bits are true.
// [RULE14] A conditional branch activates only the first condition to come true.
// [RULE15] A transition sets its target bit and clears the enabling bit.
// [RULE16] Combine and pop fill the vacated bottom level with zero.
module lsb_unit #(
   parameter int DEPTH = lsb_pkg::STACK_DEPTH,
   parameter int SBITS = lsb_pkg::STATE_BITS
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire lsb_pkg::lsb_stk_cmd_t stk_cmd_in,
   input wire lsb_pkg::lsb_alu_req_t alu_req_in,
   input wire lsb_pkg::lsb_seq_req_t seq_req_in,
   output logic [DEPTH-1:0] stack_levels_out,
   output logic stack_top_out,
   output lsb_pkg::lsb_alu_res_t alu_res_out,
   output logic zero_result_flag_out,
   output logic [SBITS-1:0] state_bits_out
);

   // ----------------------------------------------------------------
   // Logic stack
   // ----------------------------------------------------------------
   lsb_stack #(
      .DEPTH(DEPTH)
   ) lsb_stack_inst (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .cmd_in(stk_cmd_in),
      .levels_out(stack_levels_out)
   );

   assign stack_top_out = stack_levels_out[0];

   // ----------------------------------------------------------------
   // Bitwise datapath
   // ----------------------------------------------------------------
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] raw;
   logic [31:0] next_data;
   wire is_inv = alu_req_in.op == lsb_pkg::LSB_OP_INV;

   // Unused upper operand bits are masked so AND, OR and XOR results read as zero there
   assign op_a = alu_req_in.width == lsb_pkg::LSB_W_BYTE ? {24'h000000, alu_req_in.first_operand[7:0]}
      : alu_req_in.width == lsb_pkg::LSB_W_WORD ? {16'h0000, alu_req_in.first_operand[15:0]}
      : alu_req_in.first_operand;
   assign op_b = alu_req_in.width == lsb_pkg::LSB_W_BYTE ? {24'h000000, alu_req_in.second_operand[7:0]}
      : alu_req_in.width == lsb_pkg::LSB_W_WORD ? {16'h0000, alu_req_in.second_operand[15:0]}
      : alu_req_in.second_operand;

   // [RULE6] [RULE7] [RULE8] operation select
   assign raw = alu_req_in.op == lsb_pkg::LSB_OP_AND ? (op_a & op_b)
      : alu_req_in.op == lsb_pkg::LSB_OP_OR ? (op_a | op_b)
      : alu_req_in.op == lsb_pkg::LSB_OP_XOR ? (op_a ^ op_b)
      : ~op_a;

   // Truncate to the requested width after inversion
   // [RULE9] [RULE10] [RULE11] width masking
   assign next_data = alu_req_in.width == lsb_pkg::LSB_W_BYTE ? {24'h000000, raw[7:0]}
      : alu_req_in.width == lsb_pkg::LSB_W_WORD ? {16'h0000, raw[15:0]}
      : raw;

   // Zero flag only on byte and word invert; double word leaves it alone
   wire zero_upd = alu_req_in.valid && is_inv && alu_req_in.width != lsb_pkg::LSB_W_DWORD;
   wire zero_val = next_data == 32'h0000_0000;

   // Result register and zero flag
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         alu_res_out <= '0;
         zero_result_flag_out <= 1'b0;
      end else begin
         alu_res_out.valid <= alu_req_in.valid;
         alu_res_out.width <= alu_req_in.width;
         alu_res_out.zero_update <= zero_upd;
         alu_res_out.zero_value <= zero_val;
         if (alu_req_in.valid) begin
            alu_res_out.data <= next_data;
         end
         // [RULE9] [RULE10] zero flag update
         if (zero_upd) begin
            zero_result_flag_out <= zero_val;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequence state bits
   // ----------------------------------------------------------------
   logic [SBITS-1:0] state;
   logic [SBITS-1:0] fire;
   logic [SBITS-1:0] first_fire;
   logic [SBITS-1:0] set_mask;
   logic [SBITS-1:0] next_state;
   // An empty enabling mask stands outside any segment and fires on its
   // condition alone; without it no step could ever be set after reset
   wire enabled = seq_req_in.valid
      && (seq_req_in.current == '0 || (state & seq_req_in.current) != '0);
   // [RULE13] join needs all completion bits
   wire join_ok = seq_req_in.valid && seq_req_in.join_need != '0
      && ((state & seq_req_in.join_need) == seq_req_in.join_need);

   // Targets whose condition is true this evaluation
   assign fire = enabled ? (seq_req_in.targets & seq_req_in.cond) : '0;
   // [RULE14] lowest index wins when conditions arrive together
   assign first_fire = fire & (~fire + 1'b1);
   // [RULE12] diverge sets every fired target together
   assign set_mask = (seq_req_in.exclusive ? first_fire : fire)
      | (join_ok ? seq_req_in.join_target : '0);

   // [RULE15] set targets, clear enabling bit; join consumes its inputs
   always_comb begin
      next_state = state;
      if (fire != '0) begin
         next_state = next_state & ~seq_req_in.current;
      end
      if (join_ok) begin
         next_state = next_state & ~seq_req_in.join_need;
      end
      next_state = next_state | set_mask;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state <= lsb_pkg::RST_STATE;
      end else begin
         state <= next_state;
      end
   end

   assign state_bits_out = state;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_byte_req;
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_BYTE && !is_inv;
   endsequence

   a_byte_logic: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE6]
      s_byte_req |=> alu_res_out.data[31:8] == 24'h000000)
      else $error("byte result spills past 8 bits");
   a_word_logic: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE7]
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_WORD
      && alu_req_in.op == lsb_pkg::LSB_OP_XOR |=> alu_res_out.data[15:0]
      == $past(alu_req_in.first_operand[15:0] ^ alu_req_in.second_operand[15:0]))
      else $error("word xor wrong");
   a_dword_logic: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE8]
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_DWORD
      && alu_req_in.op == lsb_pkg::LSB_OP_AND |=> alu_res_out.data
      == $past(alu_req_in.first_operand & alu_req_in.second_operand))
      else $error("dword and wrong");
   a_byte_invert: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE9]
      alu_req_in.valid && is_inv && alu_req_in.width == lsb_pkg::LSB_W_BYTE
      |=> alu_res_out.data[7:0] == ~$past(alu_req_in.first_operand[7:0])
      && zero_result_flag_out == (alu_res_out.data[7:0] == 8'h00))
      else $error("byte invert wrong");
   a_word_invert: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE10]
      alu_req_in.valid && is_inv && alu_req_in.width == lsb_pkg::LSB_W_WORD
      |=> alu_res_out.data[15:0] == ~$past(alu_req_in.first_operand[15:0])
      && zero_result_flag_out == (alu_res_out.data[15:0] == 16'h0000))
      else $error("word invert wrong");
   a_dword_invert: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE11]
      alu_req_in.valid && is_inv && alu_req_in.width == lsb_pkg::LSB_W_DWORD
      |=> alu_res_out.data == ~$past(alu_req_in.first_operand) && $stable(zero_result_flag_out))
      else $error("dword invert wrong");
   a_diverge_all: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE12]
      !seq_req_in.exclusive && fire != '0 |=> (state & $past(fire)) == $past(fire))
      else $error("diverge missed a target");
   a_join_wait: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE13]
      seq_req_in.valid && seq_req_in.join_need != '0 && !join_ok && fire == '0
      && (state & seq_req_in.join_target) == '0 |=> (state & $past(seq_req_in.join_target)) == '0)
      else $error("join fired early");
   a_branch_one: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE14]
      seq_req_in.exclusive && !join_ok && fire != '0
      |=> $countones(state & $past(seq_req_in.targets) & ~$past(state)) <= 1)
      else $error("branch activated more than one stream");
   a_step_clear: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE15]
      fire != '0 && (seq_req_in.current & set_mask) == '0 && !join_ok
      |=> (state & $past(seq_req_in.current)) == '0)
      else $error("enabling state not cleared");

   // Three more operation and width pairs, so every mux leg is watched
   a_byte_or: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE6]
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_BYTE
      && alu_req_in.op == lsb_pkg::LSB_OP_OR |=> alu_res_out.data[7:0]
      == $past(alu_req_in.first_operand[7:0] | alu_req_in.second_operand[7:0]))
      else $error("byte or wrong");
   a_word_and: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE7]
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_WORD
      && alu_req_in.op == lsb_pkg::LSB_OP_AND |=> alu_res_out.data
      == {16'h0000, $past(alu_req_in.first_operand[15:0] & alu_req_in.second_operand[15:0])})
      else $error("word and wrong");
   a_dword_xor: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE8]
      alu_req_in.valid && alu_req_in.width == lsb_pkg::LSB_W_DWORD
      && alu_req_in.op == lsb_pkg::LSB_OP_XOR |=> alu_res_out.data
      == $past(alu_req_in.first_operand ^ alu_req_in.second_operand))
      else $error("dword xor wrong");
   // Flag moves only on byte or word invert
   a_zero_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE9]
      !zero_upd |=> $stable(zero_result_flag_out))
      else $error("zero flag moved without invert");
   a_join_fire: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE13]
      join_ok |=> (state & $past(seq_req_in.join_target)) == $past(seq_req_in.join_target))
      else $error("join target not set");
   // A step whose enabling bit is off must leave the state alone
   a_step_idle: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE15]
      seq_req_in.valid && !enabled && !join_ok |=> $stable(state))
      else $error("state moved without enable");

endmodule // lsb_unit

/* test/lsb_seqr_model.sv */
/*
 * Sequencer stand-in for the logic unit: issues stack, bitwise and
 * sequence-step requests, one cycle each, then returns to idle.
 * Assumes the unit samples its requests on core_clk_in rising edges.
 */
`timescale 1ns/1ps

module lsb_seqr_model (
   input wire logic core_clk_in,
   output lsb_pkg::lsb_stk_cmd_t stk_cmd_out,
   output lsb_pkg::lsb_alu_req_t alu_req_out,
   output lsb_pkg::lsb_seq_req_t seq_req_out
);
   // ----------------------------------------------------------------
   // Idle levels at time zero
   // ----------------------------------------------------------------
   initial begin
      stk_cmd_out = lsb_pkg::LSB_STK_NONE;
      alu_req_out = '0;
      seq_req_out = '0;
   end

   // One stack command, dropped at the edge that takes it
   task automatic issue_stk(input lsb_pkg::lsb_stk_cmd_t c);
      @(posedge core_clk_in);
      stk_cmd_out <= c;
      @(posedge core_clk_in);
      stk_cmd_out <= lsb_pkg::LSB_STK_NONE;
   endtask

   // One bitwise request; operands kept so stale data is not hidden
   task automatic issue_alu(input lsb_pkg::lsb_alu_req_t r);
      @(posedge core_clk_in);
      alu_req_out <= r;
      @(posedge core_clk_in);
      alu_req_out.valid <= 1'h0;
   endtask

   // One evaluation of transitions
   task automatic issue_seq(input lsb_pkg::lsb_seq_req_t r);
      @(posedge core_clk_in);
      seq_req_out <= r;
      @(posedge core_clk_in);
      seq_req_out.valid <= 1'h0;
   endtask
endmodule // lsb_seqr_model

/* test/logic_stack_bitwise_unit_tb_top.sv */
/*
 * Self-checking bench for the logic unit: reset values, stack commands,
 * bitwise results per width and the zero-result flag, sequence stepping.
 * Assumes the sequencer model drives every request input.
 */
`timescale 1ns/1ps

module logic_stack_bitwise_unit_tb_top;
   logic core_clk_in;
   logic rst_in;
   lsb_pkg::lsb_stk_cmd_t stk_cmd;
   lsb_pkg::lsb_alu_req_t alu_req;
   lsb_pkg::lsb_seq_req_t seq_req;
   logic [8:0] levels;
   logic top;
   lsb_pkg::lsb_alu_res_t res;
   logic zflag;
   logic [7:0] state;
   int bad_count = 0;
   int n_tests = 0;

   // ----------------------------------------------------------------
   // Clock, reset and instances
   // ----------------------------------------------------------------
   initial begin
      core_clk_in = 1'h0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   lsb_unit lsb_unit_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .stk_cmd_in(stk_cmd),
      .alu_req_in(alu_req), .seq_req_in(seq_req), .stack_levels_out(levels),
      .stack_top_out(top), .alu_res_out(res), .zero_result_flag_out(zflag),
      .state_bits_out(state));

   lsb_seqr_model lsb_seqr_model_inst (.core_clk_in(core_clk_in), .stk_cmd_out(stk_cmd),
      .alu_req_out(alu_req), .seq_req_out(seq_req));

   // ----------------------------------------------------------------
   // Shared checking
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Own stack reference, bit 0 is the top
   function automatic logic [8:0] stk_next(input logic [8:0] s, input lsb_pkg::lsb_stk_cmd_t c);
      case (c)
         lsb_pkg::LSB_STK_AND: return {1'h0, s[8:2], s[0] & s[1]};
         lsb_pkg::LSB_STK_OR: return {1'h0, s[8:2], s[0] | s[1]};
         lsb_pkg::LSB_STK_DUP: return {s[7:0], s[0]};
         lsb_pkg::LSB_STK_COPY: return {s[8:1], s[1]};
         lsb_pkg::LSB_STK_POP: return {1'h0, s[8:1]};
         lsb_pkg::LSB_STK_PUSH0: return {s[7:0], 1'h0};
         lsb_pkg::LSB_STK_PUSH1: return {s[7:0], 1'h1};
         default: return s;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Every output is zero straight after reset
   task automatic test_reset();
      check("levels", 32'h0, {23'h0, levels});
      check("alu valid", 32'h0, {31'h0, res.valid});
      check("zero flag", 32'h0, {31'h0, zflag});
      check("state", 32'h0, {24'h0, state});
   endtask

   // Fill with ones, then each command on mixed levels
   task automatic test_stack();
      lsb_pkg::lsb_stk_cmd_t cmds [10];
      logic [8:0] exp;
      cmds = '{lsb_pkg::LSB_STK_AND, lsb_pkg::LSB_STK_PUSH0, lsb_pkg::LSB_STK_OR,
               lsb_pkg::LSB_STK_PUSH0, lsb_pkg::LSB_STK_PUSH0, lsb_pkg::LSB_STK_AND,
               lsb_pkg::LSB_STK_DUP, lsb_pkg::LSB_STK_PUSH1, lsb_pkg::LSB_STK_COPY,
               lsb_pkg::LSB_STK_POP};
      exp = levels;
      // A one in the bottom level makes the zero refill visible
      repeat (9) begin
         lsb_seqr_model_inst.issue_stk(lsb_pkg::LSB_STK_PUSH1);
         exp = stk_next(exp, lsb_pkg::LSB_STK_PUSH1);
         #1;
         check("levels fill", {23'h0, exp}, {23'h0, levels});
      end
      foreach (cmds[i]) begin
         lsb_seqr_model_inst.issue_stk(cmds[i]);
         exp = stk_next(exp, cmds[i]);
         #1;
         check("levels", {23'h0, exp}, {23'h0, levels});
         check("top", {31'h0, exp[0]}, {31'h0, top});
      end
   endtask

   // One bitwise request and its one-cycle answer
   task automatic alu(input lsb_pkg::lsb_op_t op, input lsb_pkg::lsb_width_t w,
                      input logic [31:0] a, input logic [31:0] b);
      lsb_pkg::lsb_alu_req_t r;
      logic [31:0] exp;
      logic [31:0] mask;
      logic zu_exp;
      r = '{valid: 1'h1, op: op, width: w, first_operand: a, second_operand: b};
      mask = (w == lsb_pkg::LSB_W_BYTE) ? 32'h0000_00FF :
             (w == lsb_pkg::LSB_W_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      zu_exp = (op == lsb_pkg::LSB_OP_INV) && (w != lsb_pkg::LSB_W_DWORD);
      case (op)
         lsb_pkg::LSB_OP_AND: exp = a & b;
         lsb_pkg::LSB_OP_OR: exp = a | b;
         lsb_pkg::LSB_OP_XOR: exp = a ^ b;
         default: exp = ~a;
      endcase
      lsb_seqr_model_inst.issue_alu(r);
      #1;
      check("alu data", exp & mask, res.data);
      check("zero update", {31'h0, zu_exp}, {31'h0, res.zero_update});
      check("zero value", {31'h0, (exp & mask) == 32'h0}, {31'h0, res.zero_value});
      check("alu valid", 32'h1, {31'h0, res.valid});
      check("alu width", {30'h0, w}, {30'h0, res.width});
      @(posedge core_clk_in);
      #1;
      check("alu valid drop", 32'h0, {31'h0, res.valid});
   endtask

   // Every operation at every width, operands wider than the width
   task automatic test_ops();
      for (int w = 0; w < 3; w++) begin
         for (int o = 0; o < 4; o++) begin
            alu(lsb_pkg::lsb_op_t'(o), lsb_pkg::lsb_width_t'(w), 32'hF0F0_A5C3, 32'h0FF0_3C99);
         end
      end
   endtask

   // Zero flag follows byte and word invert only
   task automatic test_zero_flag();
      alu(lsb_pkg::LSB_OP_INV, lsb_pkg::LSB_W_BYTE, 32'h1234_56FF, 32'h0);
      check("zero flag", 32'h1, {31'h0, zflag});
      alu(lsb_pkg::LSB_OP_AND, lsb_pkg::LSB_W_BYTE, 32'h0000_000F, 32'h0000_00F1);
      check("zero flag", 32'h1, {31'h0, zflag});
      alu(lsb_pkg::LSB_OP_INV, lsb_pkg::LSB_W_DWORD, 32'h0000_0000, 32'h0);
      check("zero flag", 32'h1, {31'h0, zflag});
      alu(lsb_pkg::LSB_OP_INV, lsb_pkg::LSB_W_WORD, 32'hFFFF_1234, 32'h0);
      check("zero flag", 32'h0, {31'h0, zflag});
      alu(lsb_pkg::LSB_OP_INV, lsb_pkg::LSB_W_WORD, 32'h0000_FFFF, 32'h0);
      check("zero flag", 32'h1, {31'h0, zflag});
   endtask

   // No active state: neither a branch nor a join may fire
   task automatic test_seq_idle();
      lsb_pkg::lsb_seq_req_t r;
      r = '{valid: 1'h1, current: 8'h01, targets: 8'h06, cond: 8'h06,
            join_need: 8'h00, join_target: 8'h00, exclusive: 1'h0};
      lsb_seqr_model_inst.issue_seq(r);
      #1;
      check("state", 32'h0, {24'h0, state});
      r.join_need = 8'h18;
      r.join_target = 8'h20;
      r.exclusive = 1'h1;
      lsb_seqr_model_inst.issue_seq(r);
      #1;
      check("state", 32'h0, {24'h0, state});
   endtask

   // One evaluation of transitions and the state bits it must leave
   task automatic seq_step(input logic [7:0] cur, input logic [7:0] tgt, input logic [7:0] cnd,
                           input logic [7:0] need, input logic [7:0] jt, input logic excl,
                           input logic [7:0] exp);
      lsb_pkg::lsb_seq_req_t r;
      r = '{valid: 1'h1, current: cur, targets: tgt, cond: cnd,
            join_need: need, join_target: jt, exclusive: excl};
      lsb_seqr_model_inst.issue_seq(r);
      #1;
      check("state", {24'h0, exp}, {24'h0, state});
   endtask

   // Entry, diverge, join that waits then fires, exclusive branches
   task automatic test_seq();
      seq_step(8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 1'h0, 8'h01);
      seq_step(8'h01, 8'h06, 8'h06, 8'h00, 8'h00, 1'h0, 8'h06);
      seq_step(8'h02, 8'h08, 8'h08, 8'h00, 8'h00, 1'h0, 8'h0C);
      seq_step(8'h00, 8'h00, 8'h00, 8'h18, 8'h20, 1'h0, 8'h0C);
      seq_step(8'h04, 8'h10, 8'h10, 8'h00, 8'h00, 1'h0, 8'h18);
      seq_step(8'h00, 8'h00, 8'h00, 8'h18, 8'h20, 1'h0, 8'h20);
      seq_step(8'h20, 8'hC0, 8'hC0, 8'h00, 8'h00, 1'h1, 8'h40);
      seq_step(8'h40, 8'h03, 8'h02, 8'h00, 8'h00, 1'h1, 8'h02);
      seq_step(8'h01, 8'h80, 8'h80, 8'h00, 8'h00, 1'h0, 8'h02);
   endtask

   // Reset in mid-run clears all, and the first step after it is taken
   task automatic test_mid_reset();
      @(posedge core_clk_in);
      rst_in <= 1'h1;
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'h0;
      #1;
      check("levels", 32'h0, {23'h0, levels});
      check("alu data", 32'h0, res.data);
      check("zero flag", 32'h0, {31'h0, zflag});
      check("state", 32'h0, {24'h0, state});
      seq_step(8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 1'h0, 8'h01);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst_in = 1'h1;
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'h0;
      #1;
      test_reset();
      test_stack();
      test_ops();
      test_zero_flag();
      test_seq_idle();
      test_seq();
      test_mid_reset();
      results();
   end

   // Whole run is some 130 cycles; far longer means a hang
   initial begin
      #(5000 * 50);
      bad_count++;
      results();
   end
endmodule // logic_stack_bitwise_unit_tb_top
